// ### src/fsp_consts.svh
// Named constants for the frame sync pin block: offsets, fields, resets.
// Included by bare name from every design file that decodes registers.
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave
`define FSP_OFS_RX_CLK   5'h00
`define FSP_OFS_TX_CLK   5'h04
`define FSP_OFS_COM_CTRL 5'h08
`define FSP_OFS_COM_STAT 5'h0c
`define FSP_OFS_PORT_CTL 5'h10
`define FSP_OFS_PORT_DIR 5'h14
`define FSP_OFS_PORT_DAT 5'h18

// Field positions
`define FSP_B_RX_FS_DIR  0
`define FSP_B_TX_FS_DIR  0
`define FSP_B_SYNC_MODE  0
`define FSP_B_TXBUF_OPT  1
`define FSP_B_OUT_FLAG   2
`define FSP_B_NETWORK    3
`define FSP_B_IN_FLAG    0
`define FSP_B_RX_PIN     0
`define FSP_B_TX_PIN     1
`define FSP_B_LANE0      0

// Reset and idle values
`define FSP_RST_BIT      1'b0
`define FSP_RST_PORT     2'h0
`define FSP_RST_WAIT     1'b1
`define FSP_RD_ZERO      32'h0

`endif

// ### src/fsp_pkg.sv
// Types shared by the frame sync pin block.
// Assumes nothing of its surroundings.
package fsp_pkg;

	// Pin mode, coded as {port control bit, port direction bit}
	typedef enum logic [1:0] {
		FSP_DISC   = 2'b00,
		FSP_GPOUT  = 2'b01,
		FSP_GPIN   = 2'b10,
		FSP_PERIPH = 2'b11
	} fsp_pin_mode_t;

	// Function of the receiver frame sync pin in peripheral mode
	typedef enum logic [1:0] {
		FSP_RX_FS    = 2'b00,
		FSP_RX_FLAG  = 2'b01,
		FSP_RX_BUFEN = 2'b10,
		FSP_RX_IDLE  = 2'b11
	} fsp_rx_fn_t;

endpackage : fsp_pkg

// ### src/fsp_sync2.sv
// Two flip-flop level synchroniser of parameter width.
// Assumes each bit is a slow level; bits of a vector may land a cycle apart.
`timescale 1ns/10ps
module fsp_sync2 #(
	parameter int W = 1
) (
	// Destination clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Levels in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : fsp_sync2

// ### src/fsp_pin_ctl.sv
// Output driver control for one frame sync pin.
// Assumes mode and peripheral drive come from the same clock domain.
`timescale 1ns/10ps
`include "fsp_consts.svh"
module fsp_pin_ctl (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst_n,
	// Mode and values
	input  fsp_pkg::fsp_pin_mode_t mode,
	input  wire logic            per_drive,
	input  wire logic            per_val,
	input  wire logic            gpio_val,
	// Pin drive
	output logic                 oe_n_q,
	output logic                 out_q
);
	import fsp_pkg::*;

	// Driver on only for a general output or a driving peripheral function
	wire drive_d = (mode == FSP_GPOUT) | ((mode == FSP_PERIPH) & per_drive);
	wire out_d   = drive_d & ((mode == FSP_PERIPH) ? per_val : gpio_val);

	// Reset leaves the pin disconnected
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_n_q <= ~`FSP_RST_BIT;
			out_q  <= `FSP_RST_BIT;
		end else begin
			oe_n_q <= ~drive_d;
			out_q  <= out_d;
		end
	end

	a_pin_release: assert property (@(posedge clk) disable iff (!rst_n)
		(mode == FSP_DISC || mode == FSP_GPIN) |=> (oe_n_q && !out_q))
		else $error("pin driven while disconnected or input");

	a_gpio_drive: assert property (@(posedge clk) disable iff (!rst_n)
		(mode == FSP_GPOUT) |=> (!oe_n_q && out_q == $past(gpio_val)))
		else $error("general output not driven with its data");
endmodule : fsp_pin_ctl

// ### src/fsp_frame_sync_pins.sv
// Frame sync pin logic of the second audio serial unit: pin muxing,
// serial flag one, transmit buffer enable and general-purpose lines.
// Assumes an Avalon-MM master on mclk and a serial core on frame_clk.
// Pins are steered only while frame_clk runs.
`timescale 1ns/10ps
`include "fsp_consts.svh"

module fsp_frame_sync_pins (
	// System clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Link clock
	input  wire logic        frame_clk,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Serial core, frame_clk domain
	input  wire logic        rx_fs_gen,
	input  wire logic        tx_fs_gen,
	input  wire logic        tx_buf_en,
	input  wire logic        slot_strobe,
	output logic             rx_framing_fs,
	output logic             tx_framing_fs,
	// Receiver frame sync pin
	input  wire logic        receiver_frame_sync_pin_i,
	output logic             receiver_frame_sync_pin_o,
	output logic             receiver_frame_sync_pin_oe_n,
	// Transmitter frame sync pin
	input  wire logic        transmitter_frame_sync_pin_i,
	output logic             transmitter_frame_sync_pin_o,
	output logic             transmitter_frame_sync_pin_oe_n
);
	import fsp_pkg::*;

	// Register state, mclk domain
	logic        rx_dir_q;
	logic        tx_dir_q;
	logic        sync_mode_q;
	logic        txbuf_opt_q;
	logic        out_flag_q;
	logic        network_q;
	logic [1:0]  port_ctl_q;
	logic [1:0]  port_dir_q;
	logic [1:0]  port_dat_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// Values brought into mclk
	logic        in_flag_m;
	logic [1:0]  pins_m;

	// Configuration and pin levels seen in frame_clk
	logic        rdir_l;
	logic        tdir_l;
	logic        smode_l;
	logic        txbuf_l;
	logic        oflag_l;
	logic        net_l;
	logic [1:0]  pctl_l;
	logic [1:0]  pdir_l;
	logic [1:0]  pdat_l;
	logic        rpin_s;
	logic        tpin_s;

	// Link side state
	logic        fs_prev_q;
	logic        flag_pin_q;
	logic        in_flag_lk_q;
	logic        rx_framing_q;
	logic        tx_framing_q;
	logic        rx_oe_n_q;
	logic        rx_o_q;
	logic        tx_oe_n_q;
	logic        tx_o_q;

	// Bus decode: first edge of a request drops waitrequest,
	// the edge that sees it low commits the write
	wire req      = avs_read | avs_write;
	wire take     = req & wait_q;
	wire commit   = avs_write & ~wait_q & avs_byteenable[`FSP_B_LANE0];
	wire hit_rx   = (avs_address == `FSP_OFS_RX_CLK);
	wire hit_tx   = (avs_address == `FSP_OFS_TX_CLK);
	wire hit_com  = (avs_address == `FSP_OFS_COM_CTRL);
	wire hit_stat = (avs_address == `FSP_OFS_COM_STAT);
	wire hit_pctl = (avs_address == `FSP_OFS_PORT_CTL);
	wire hit_pdir = (avs_address == `FSP_OFS_PORT_DIR);
	wire hit_pdat = (avs_address == `FSP_OFS_PORT_DAT);
	wire wr_rx    = commit & hit_rx;
	wire wr_tx    = commit & hit_tx;
	wire wr_com   = commit & hit_com;
	wire wr_pctl  = commit & hit_pctl;
	wire wr_pdir  = commit & hit_pdir;
	wire wr_pdat  = commit & hit_pdat;

	// Read word; unmapped offsets read as zero
	always_comb begin
		rdata_d = `FSP_RD_ZERO;
		if (hit_rx)
			rdata_d[`FSP_B_RX_FS_DIR] = rx_dir_q;
		if (hit_tx)
			rdata_d[`FSP_B_TX_FS_DIR] = tx_dir_q;
		if (hit_com) begin
			rdata_d[`FSP_B_SYNC_MODE] = sync_mode_q;
			rdata_d[`FSP_B_TXBUF_OPT] = txbuf_opt_q;
			rdata_d[`FSP_B_OUT_FLAG]  = out_flag_q;
			rdata_d[`FSP_B_NETWORK]   = network_q;
		end
		if (hit_stat)
			rdata_d[`FSP_B_IN_FLAG] = in_flag_m;
		if (hit_pctl)
			rdata_d[`FSP_B_TX_PIN:`FSP_B_RX_PIN] = port_ctl_q;
		if (hit_pdir)
			rdata_d[`FSP_B_TX_PIN:`FSP_B_RX_PIN] = port_dir_q;
		if (hit_pdat)
			rdata_d[`FSP_B_TX_PIN:`FSP_B_RX_PIN] = pins_m;
	end

	// Handshake: one wait cycle, answer registered
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q  <= `FSP_RST_WAIT;
			rdata_q <= `FSP_RD_ZERO;
		end else begin
			wait_q  <= ~take;
			if (take)
				rdata_q <= rdata_d;
		end
	end

	// Clock control bits
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_dir_q <= `FSP_RST_BIT;
			tx_dir_q <= `FSP_RST_BIT;
		end else begin
			if (wr_rx)
				rx_dir_q <= avs_writedata[`FSP_B_RX_FS_DIR];
			if (wr_tx)
				tx_dir_q <= avs_writedata[`FSP_B_TX_FS_DIR];
		end
	end

	// Common control bits
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_mode_q <= `FSP_RST_BIT;
			txbuf_opt_q <= `FSP_RST_BIT;
			out_flag_q  <= `FSP_RST_BIT;
			network_q   <= `FSP_RST_BIT;
		end else if (wr_com) begin
			sync_mode_q <= avs_writedata[`FSP_B_SYNC_MODE];
			txbuf_opt_q <= avs_writedata[`FSP_B_TXBUF_OPT];
			out_flag_q  <= avs_writedata[`FSP_B_OUT_FLAG];
			network_q   <= avs_writedata[`FSP_B_NETWORK];
		end
	end

	// Port control, direction and data; reset disconnects both pins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port_ctl_q <= `FSP_RST_PORT;
			port_dir_q <= `FSP_RST_PORT;
			port_dat_q <= `FSP_RST_PORT;
		end else begin
			if (wr_pctl)
				port_ctl_q <= avs_writedata[`FSP_B_TX_PIN:`FSP_B_RX_PIN];
			if (wr_pdir)
				port_dir_q <= avs_writedata[`FSP_B_TX_PIN:`FSP_B_RX_PIN];
			if (wr_pdat)
				port_dat_q <= avs_writedata[`FSP_B_TX_PIN:`FSP_B_RX_PIN];
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;

	// Configuration levels into frame_clk; they change only under software
	// control, so a one-cycle skew between bits is harmless
	fsp_sync2 #(.W(12)) u_cfg_sync (
		.clk   (frame_clk),
		.rst_n (rst_n),
		.d     ({port_dat_q, port_dir_q, port_ctl_q, network_q, out_flag_q,
		         txbuf_opt_q, sync_mode_q, tx_dir_q, rx_dir_q}),
		.q     ({pdat_l, pdir_l, pctl_l, net_l, oflag_l,
		         txbuf_l, smode_l, tdir_l, rdir_l})
	);

	// Pin levels into frame_clk
	fsp_sync2 #(.W(2)) u_pin_lk (
		.clk   (frame_clk),
		.rst_n (rst_n),
		.d     ({transmitter_frame_sync_pin_i, receiver_frame_sync_pin_i}),
		.q     ({tpin_s, rpin_s})
	);

	// Pin levels into mclk for general-purpose reads
	fsp_sync2 #(.W(2)) u_pin_m (
		.clk   (mclk),
		.rst_n (rst_n),
		.d     ({transmitter_frame_sync_pin_i, receiver_frame_sync_pin_i}),
		.q     (pins_m)
	);

	// Captured input flag back into mclk
	fsp_sync2 #(.W(1)) u_flag_m (
		.clk   (mclk),
		.rst_n (rst_n),
		.d     (in_flag_lk_q),
		.q     (in_flag_m)
	);

	// Pin modes from port control and direction
	wire fsp_pin_mode_t rx_mode =
		fsp_pin_mode_t'({pctl_l[`FSP_B_RX_PIN], pdir_l[`FSP_B_RX_PIN]});
	wire fsp_pin_mode_t tx_mode =
		fsp_pin_mode_t'({pctl_l[`FSP_B_TX_PIN], pdir_l[`FSP_B_TX_PIN]});
	wire rx_periph = (rx_mode == FSP_PERIPH);
	wire tx_periph = (tx_mode == FSP_PERIPH);

	// Receiver pin function; buffer option with input direction is unused
	wire fsp_rx_fn_t rx_fn =
		!smode_l ? FSP_RX_FS :
		!txbuf_l ? FSP_RX_FLAG :
		rdir_l   ? FSP_RX_BUFEN : FSP_RX_IDLE;

	// Direction: frame sync and flag follow their bit, buffer enable drives
	wire rx_drive  = rdir_l & (rx_fn != FSP_RX_IDLE);
	wire rx_val    = (rx_fn == FSP_RX_FS)   ? rx_fs_gen :
	                 (rx_fn == FSP_RX_FLAG) ? flag_pin_q : tx_buf_en;
	wire flag_in   = rx_periph & (rx_fn == FSP_RX_FLAG) & ~rdir_l;

	// Frame syncs as used inside: own output or pin input
	wire tx_fs_eff = tx_periph & (tdir_l ? tx_fs_gen : tpin_s);
	wire rx_fs_eff = rx_periph & (rx_fn == FSP_RX_FS) &
	                 (rdir_l ? rx_fs_gen : rpin_s);
	wire rx_fr_d   = smode_l ? tx_fs_eff : rx_fs_eff;

	// Flag timing: slot strobe in network mode, frame start otherwise
	wire frame_rise = rx_fr_d & ~fs_prev_q;
	wire flag_evt   = net_l ? slot_strobe : frame_rise;

	// Framing outputs to the serial core
	always_ff @(posedge frame_clk or negedge rst_n) begin
		if (!rst_n) begin
			fs_prev_q    <= `FSP_RST_BIT;
			rx_framing_q <= `FSP_RST_BIT;
			tx_framing_q <= `FSP_RST_BIT;
		end else begin
			fs_prev_q    <= rx_fr_d;
			rx_framing_q <= rx_fr_d;
			tx_framing_q <= tx_fs_eff;
		end
	end

	// Flags move only on the frame or slot boundary, so the pin and
	// the status bit never change inside a slot
	always_ff @(posedge frame_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_pin_q   <= `FSP_RST_BIT;
			in_flag_lk_q <= `FSP_RST_BIT;
		end else begin
			if (flag_evt)
				flag_pin_q <= oflag_l;
			if (flag_evt & flag_in)
				in_flag_lk_q <= rpin_s;
		end
	end

	// Receiver pin driver
	fsp_pin_ctl u_rx_pin (
		.clk       (frame_clk),
		.rst_n     (rst_n),
		.mode      (rx_mode),
		.per_drive (rx_drive),
		.per_val   (rx_val),
		.gpio_val  (pdat_l[`FSP_B_RX_PIN]),
		.oe_n_q    (rx_oe_n_q),
		.out_q     (rx_o_q)
	);

	// Transmitter pin driver; direction from its own bit
	fsp_pin_ctl u_tx_pin (
		.clk       (frame_clk),
		.rst_n     (rst_n),
		.mode      (tx_mode),
		.per_drive (tdir_l),
		.per_val   (tx_fs_gen),
		.gpio_val  (pdat_l[`FSP_B_TX_PIN]),
		.oe_n_q    (tx_oe_n_q),
		.out_q     (tx_o_q)
	);

	assign receiver_frame_sync_pin_o       = rx_o_q;
	assign receiver_frame_sync_pin_oe_n    = rx_oe_n_q;
	assign transmitter_frame_sync_pin_o    = tx_o_q;
	assign transmitter_frame_sync_pin_oe_n = tx_oe_n_q;
	assign rx_framing_fs                   = rx_framing_q;
	assign tx_framing_fs                   = tx_framing_q;

	// Checks on the link side
	a_async_rx_fs: assert property (@(posedge frame_clk) disable iff (!rst_n)
		(rx_periph && !smode_l && rdir_l) |=>
		(!rx_oe_n_q && rx_o_q == $past(rx_fs_gen)))
		else $error("receive frame sync not driven in async mode");

	a_flag_out_pin: assert property (@(posedge frame_clk) disable iff (!rst_n)
		(rx_periph && smode_l && !txbuf_l && rdir_l) |=>
		(!rx_oe_n_q && rx_o_q == $past(flag_pin_q)))
		else $error("flag pin does not show output flag");

	a_buf_enable: assert property (@(posedge frame_clk) disable iff (!rst_n)
		(rx_periph && smode_l && txbuf_l && rdir_l) |=>
		(!rx_oe_n_q && rx_o_q == $past(tx_buf_en)))
		else $error("buffer enable not driven");

	a_flag_input: assert property (@(posedge frame_clk) disable iff (!rst_n)
		flag_in |=> rx_oe_n_q)
		else $error("input flag pin is driven");

	a_flag_update: assert property (@(posedge frame_clk) disable iff (!rst_n)
		if (flag_evt) (##1 flag_pin_q == $past(oflag_l)) else (##1 $stable(flag_pin_q)))
		else $error("output flag moved off its boundary");

	a_flag_capture: assert property (@(posedge frame_clk) disable iff (!rst_n)
		(flag_evt && flag_in) |=> (in_flag_lk_q == $past(rpin_s)))
		else $error("input flag not captured");

	a_sync_framing: assert property (@(posedge frame_clk) disable iff (!rst_n)
		(smode_l && tx_periph && !tdir_l) |=>
		(rx_framing_q == $past(tpin_s) && tx_framing_q == $past(tpin_s)))
		else $error("sync mode framing not from transmitter pin");

	a_async_framing: assert property (@(posedge frame_clk) disable iff (!rst_n)
		(!smode_l && rx_periph && !rdir_l) |=> (rx_framing_q == $past(rpin_s)))
		else $error("async receive framing not from receiver pin");

	a_tx_direction: assert property (@(posedge frame_clk) disable iff (!rst_n)
		tx_periph |=> (tx_oe_n_q == !$past(tdir_l)))
		else $error("transmitter pin direction wrong");

	a_rx_release: assert property (@(posedge frame_clk) disable iff (!rst_n)
		(rx_periph && !rdir_l) |=> rx_oe_n_q)
		else $error("receiver pin driven while input");

	// Checks on the bus side
	a_bus_answer: assert property (@(posedge mclk) disable iff (!rst_n)
		take |=> (!wait_q ##1 wait_q))
		else $error("waitrequest handshake wrong");

	a_port_write: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_pctl |=> (port_ctl_q == $past(avs_writedata[`FSP_B_TX_PIN:`FSP_B_RX_PIN])))
		else $error("port control write lost");
endmodule : fsp_frame_sync_pins

// ### verif/fsp_codec_model.sv
// Far-side codec model for the two frame sync pins.
// Assumes the device's registered pin outputs; the bench commands the codec levels.
`timescale 1ns/10ps
module fsp_codec_model (
	// Device side of each pin
	input  wire logic rx_o,
	input  wire logic rx_oe_n,
	input  wire logic tx_o,
	input  wire logic tx_oe_n,
	// Levels the codec puts on a released pin
	input  wire logic rx_val,
	input  wire logic tx_val,
	// Resolved wire levels
	output logic      rx_pin,
	output logic      tx_pin
);
	// Codec is frame sync master on any line the device lets go of
	assign rx_pin = !rx_oe_n ? rx_o : rx_val;
	assign tx_pin = !tx_oe_n ? tx_o : tx_val;
endmodule : fsp_codec_model

// ### verif/fsp_frame_sync_pins_tb.sv
// Self-checking bench for the frame sync pin block.
// Assumes the codec model beside it and the register map of the consts header.
`timescale 1ns/10ps
`include "fsp_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module fsp_frame_sync_pins_tb;
	logic        mclk = 1'b0;
	logic        frame_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        rx_fs_gen = 1'b0;
	logic        tx_fs_gen = 1'b0;
	logic        tx_buf_en = 1'b0;
	logic        slot_strobe = 1'b0;
	logic        rx_framing_fs, tx_framing_fs;
	logic        rx_i, rx_o, rx_oe_n, tx_i, tx_o, tx_oe_n;
	logic        rx_val = 1'b0;
	logic        tx_val = 1'b0;
	logic [31:0] q, v;
	int          failures = 0;
	int          check_count = 0;
	int          seed = 32'h0bf4319b;

	// Clocks: 100 ns system, 64 ns link; their rising edges never coincide
	always #50 mclk = ~mclk;
	always #32 frame_clk = ~frame_clk;

	fsp_frame_sync_pins i_dut (.mclk(mclk), .rst_n(rst_n), .frame_clk(frame_clk),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rx_fs_gen(rx_fs_gen), .tx_fs_gen(tx_fs_gen), .tx_buf_en(tx_buf_en),
		.slot_strobe(slot_strobe), .rx_framing_fs(rx_framing_fs),
		.tx_framing_fs(tx_framing_fs), .receiver_frame_sync_pin_i(rx_i),
		.receiver_frame_sync_pin_o(rx_o), .receiver_frame_sync_pin_oe_n(rx_oe_n),
		.transmitter_frame_sync_pin_i(tx_i), .transmitter_frame_sync_pin_o(tx_o),
		.transmitter_frame_sync_pin_oe_n(tx_oe_n));

	fsp_codec_model i_codec (.rx_o(rx_o), .rx_oe_n(rx_oe_n), .tx_o(tx_o),
		.tx_oe_n(tx_oe_n), .rx_val(rx_val), .tx_val(tx_val), .rx_pin(rx_i),
		.tx_pin(tx_i));

	// One Avalon transfer; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] rq);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		// No cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		rq = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] dq;
		bus(1'b1, a, d, 4'hf, dq);
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] rq);
		bus(1'b0, a, 32'h0, 4'hf, rq);
	endtask : rd

	// Config crosses two sync flops plus the pin flop; eight link edges covers skew
	task automatic settle;
		repeat (8) @(posedge frame_clk);
		#1;
	endtask : settle

	// Receive framing pulse driven by the codec on the transmitter pin
	task automatic frame_pulse;
		@(posedge frame_clk);
		tx_val <= 1'b1;
		repeat (4) @(posedge frame_clk);
		tx_val <= 1'b0;
		settle();
	endtask : frame_pulse

	task automatic slot_pulse;
		@(posedge frame_clk);
		slot_strobe <= 1'b1;
		@(posedge frame_clk);
		slot_strobe <= 1'b0;
		settle();
	endtask : slot_pulse

	task automatic tally_and_finish;
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// Whole run is a few hundred cycles; this only cuts a hang
	initial begin
		#3000000;
		failures++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		settle();
		// Reset state: pins released, all registers zero, unmapped reads zero
		`CHK({tx_oe_n, rx_oe_n, tx_o, rx_o}, 4'b1100)
		for (int a = 0; a < 32; a += 4) begin
			rd(a[4:0], q);
			`CHK(q, 32'h0)
		end
		// General-purpose outputs with random data, then a write with lane 0 off
		wr(`FSP_OFS_PORT_DIR, 32'h3);
		repeat (6) begin
			v = $random(seed);
			wr(`FSP_OFS_PORT_DAT, v);
			settle();
			`CHK({tx_oe_n, rx_oe_n, tx_o, rx_o}, {2'b00, v[1:0]})
		end
		bus(1'b1, `FSP_OFS_PORT_DAT, ~v, 4'he, q);
		settle();
		`CHK({tx_o, rx_o}, v[1:0])
		// General-purpose inputs: driver off, pin levels readable
		wr(`FSP_OFS_PORT_CTL, 32'h3);
		wr(`FSP_OFS_PORT_DIR, 32'h0);
		v = $random(seed);
		rx_val <= v[0];
		tx_val <= v[1];
		settle();
		`CHK({tx_oe_n, rx_oe_n}, 2'b11)
		rd(`FSP_OFS_PORT_DAT, q);
		`CHK(q[1:0], v[1:0])
		// Frame sync function, async, both pins outputs
		wr(`FSP_OFS_PORT_DIR, 32'h3);
		wr(`FSP_OFS_RX_CLK, 32'h1);
		wr(`FSP_OFS_TX_CLK, 32'h1);
		settle();
		repeat (8) begin
			v = $random(seed);
			@(posedge frame_clk);
			rx_fs_gen <= v[0];
			tx_fs_gen <= v[1];
			repeat (2) @(posedge frame_clk);
			#1;
			`CHK({rx_oe_n, rx_o}, {1'b0, v[0]})
			`CHK({tx_oe_n, tx_o}, {1'b0, v[1]})
			`CHK(rx_framing_fs, v[0])
			`CHK(tx_framing_fs, v[1])
		end
		// Both pins inputs, async: each direction framed by its own pin
		wr(`FSP_OFS_RX_CLK, 32'h0);
		wr(`FSP_OFS_TX_CLK, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rx_val <= i[0];
			tx_val <= i[1];
			settle();
			`CHK({tx_oe_n, rx_oe_n}, 2'b11)
			`CHK(rx_framing_fs, i[0])
			`CHK(tx_framing_fs, i[1])
		end
		// Sync mode: receivers follow the transmitter pin
		wr(`FSP_OFS_COM_CTRL, 32'h1);
		for (int i = 1; i < 3; i++) begin
			rx_val <= i[0];
			tx_val <= i[1];
			settle();
			`CHK(rx_framing_fs, i[1])
		end
		// Output flag: changes only at the frame event, then at the slot event
		tx_val <= 1'b0;
		wr(`FSP_OFS_RX_CLK, 32'h1);
		settle();
		`CHK({rx_oe_n, rx_o}, 2'b00)
		wr(`FSP_OFS_COM_CTRL, 32'h5);
		settle();
		`CHK(rx_o, 1'b0)
		frame_pulse();
		`CHK(rx_o, 1'b1)
		wr(`FSP_OFS_COM_CTRL, 32'h9);
		settle();
		`CHK(rx_o, 1'b1)
		slot_pulse();
		`CHK(rx_o, 1'b0)
		// Input flag: captured at the frame event, then at the slot event
		wr(`FSP_OFS_COM_CTRL, 32'h1);
		wr(`FSP_OFS_RX_CLK, 32'h0);
		rx_val <= 1'b1;
		settle();
		`CHK(rx_oe_n, 1'b1)
		frame_pulse();
		rd(`FSP_OFS_COM_STAT, q);
		`CHK(q, 32'h1)
		rx_val <= 1'b0;
		wr(`FSP_OFS_COM_CTRL, 32'h9);
		// Network mode must reach the link side before the slot strobe
		settle();
		slot_pulse();
		rd(`FSP_OFS_COM_STAT, q);
		`CHK(q, 32'h0)
		// External buffer enable, then released when direction is input
		wr(`FSP_OFS_COM_CTRL, 32'h3);
		wr(`FSP_OFS_RX_CLK, 32'h1);
		settle();
		repeat (6) begin
			v = $random(seed);
			@(posedge frame_clk);
			tx_buf_en <= v[0];
			repeat (2) @(posedge frame_clk);
			#1;
			`CHK({rx_oe_n, rx_o}, {1'b0, v[0]})
		end
		wr(`FSP_OFS_RX_CLK, 32'h0);
		settle();
		`CHK(rx_oe_n, 1'b1)
		// Reset in mid-run puts both pins back to disconnected
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (4) @(posedge mclk);
		`CHK({tx_oe_n, rx_oe_n, avs_waitrequest}, 3'b111)
		rst_n <= 1'b1;
		settle();
		`CHK({tx_oe_n, rx_oe_n, tx_o, rx_o}, 4'b1100)
		rd(`FSP_OFS_PORT_CTL, q);
		`CHK(q, 32'h0)
		tally_and_finish();
	end
endmodule : fsp_frame_sync_pins_tb
